// >>> core/fic_iap_ctrl.sv
module fic_iap_ctrl import fic_pkg::*; #(
	parameter int EW_SHORT_CYC = EW_SHORT_CYCLES,
	parameter int EW_LONG_CYC  = EW_LONG_CYCLES,
	parameter int UNLOCK_CYC   = UNLOCK_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Processor hold
	output logic             cpu_halt_o
);
	localparam int WORDS = 1 << PAGE_OFS_W;

	fic_state_t                 state;
	logic [23:0]                cnt;
	logic [23:0]                ew_last;
	logic [23:0]                ucnt;
	logic [1:0]                 div;
	logic                       en_flag;
	logic [2:0]                 op_sel;
	logic                       arm;
	logic                       trig;
	logic                       rd_en;
	logic                       rd_trig;
	logic                       tsel;
	logic [FLASH_ADDR_W-1:0]    addr;
	logic [7:0]                 data_lo;
	logic [7:0]                 data_hi;
	logic [7:0]                 key [6];
	logic [WORD_W-1:0]          wbuf [WORDS];
	logic [WORDS-1:0]           tag;
	logic [FLASH_ADDR_W-PAGE_OFS_W-1:0] op_page;
	logic [(WORD_W<<PAGE_OFS_W)-1:0] page_flat;
	logic [WORD_W-1:0]          flash_rd;
	logic [7:0]                 rd_mux;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic       bus_req;
	logic       hit;
	logic [7:0] reg_idx;
	logic [7:0] wdat;
	logic [2:0] new_mode;
	assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign reg_idx  = wb_adr_i[9:2];
	assign hit      = (wb_adr_i[31:10] == 22'h0) && (wb_adr_i[1:0] == 2'h0);
	assign wdat     = wb_dat_i[7:0];
	assign new_mode = wdat[FC0_MODE_LSB +: 3];

	function automatic logic wr_to(input logic [7:0] idx);
		return bus_req && wb_we_i && wb_sel_i[0] && hit && (reg_idx == idx); // RULE26
	endfunction

	// Key registers interleave low and high bytes on the bus
	function automatic int key_slot(input logic [7:0] idx);
		logic [7:0] d;
		d = idx - IDX_K1L;
		return int'(d[0]) * 3 + int'(d[2:1]);
	endfunction

	logic wr_fc0;
	logic wr_fc1;
	logic ofs_step;
	logic start_ew;
	logic start_rd;
	logic ew_done;
	logic rd_done;
	logic key_ok;
	// Procedural, so the bus signals read inside the function stay in the sensitivity
	always_comb wr_fc0 = wr_to(IDX_FC0);
	always_comb wr_fc1 = wr_to(IDX_FC1);
	always_comb ofs_step = wr_to(IDX_D0H) && state == ST_IDLE && (op_sel == MODE_WRITE || op_sel == MODE_ERASE);
	assign start_ew = wr_fc0 && wdat[FC0_TRIG_BIT] && state == ST_IDLE && en_flag
		&& (new_mode == MODE_WRITE || new_mode == MODE_ERASE); // RULE1 RULE2 RULE9
	assign start_rd = wr_fc0 && wdat[FC0_RTRIG_BIT] && state == ST_IDLE
		&& wdat[FC0_RDEN_BIT] && new_mode == MODE_READ; // RULE17 RULE19
	assign ew_done  = (state == ST_ERASE || state == ST_WRITE) && cnt == ew_last;
	assign rd_done  = state == ST_READ && div == 2'(CLKS_PER_INSTR - 1) && cnt == 24'(READ_INSTR_CYCLES - 1);
	assign key_ok   = {key[0], key[1], key[2], key[3], key[4], wdat} == KEY_PATTERN; // RULE22

	always_comb begin
		rd_mux = 8'h00;
		if (hit) begin
			unique case (reg_idx)
				IDX_FC0:  rd_mux = {en_flag, op_sel, arm, trig, rd_en, rd_trig};
				IDX_FC2:  rd_mux = {7'h00, tsel};
				IDX_FLASH_ADDRESS_LOW_REG: rd_mux = addr[7:0];
				IDX_FLASH_ADDRESS_HIGH_REG: rd_mux = {3'h0, addr[FLASH_ADDR_W-1:8]};
				IDX_D0L:  rd_mux = data_lo;
				IDX_D0H:  rd_mux = data_hi;
				default: begin
					if (reg_idx >= IDX_K1L && reg_idx <= IDX_K3H) begin
						rd_mux = key[key_slot(reg_idx)];
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				wb_dat_o <= {24'h00_0000, rd_mux};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control fields

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_sel <= MODE_RST;
			rd_en  <= 1'b0;
			tsel   <= 1'b0;
		end else begin
			if (wr_fc0) begin
				op_sel <= new_mode;
				rd_en  <= wdat[FC0_RDEN_BIT];
			end
			if (wr_to(IDX_FC2)) begin
				tsel <= wdat[FC2_TSEL_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unlock window and enabled flag

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arm     <= 1'b0;
			ucnt    <= 24'h00_0000;
			en_flag <= 1'b0;
		end else begin
			if (wr_fc0 && wdat[FC0_ARM_BIT] && new_mode == MODE_UNLOCK && !arm) begin
				arm  <= 1'b1;
				ucnt <= 24'h00_0000;
			end else if (arm) begin
				ucnt <= ucnt + 24'h00_0001;
				if (ucnt == 24'(UNLOCK_CYC - 1)) begin
					arm <= 1'b0; // RULE22
				end
			end
			// Set beats a simultaneous clear
			if (arm && op_sel == MODE_UNLOCK && wr_to(IDX_K3H) && key_ok) begin
				en_flag <= 1'b1; // RULE22
			end else if (wr_fc0 && !wdat[FC0_EN_BIT]) begin
				en_flag <= 1'b0; // RULE15
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 6; i++) begin
				key[i] <= 8'h00;
			end
		end else if (bus_req && reg_idx >= IDX_K1L && reg_idx <= IDX_K3H && wr_to(reg_idx)) begin
			key[key_slot(reg_idx)] <= wdat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address and data registers

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			addr <= '0;
		end else if (wr_to(IDX_FLASH_ADDRESS_LOW_REG)) begin
			addr[7:0] <= wdat;
		end else if (wr_to(IDX_FLASH_ADDRESS_HIGH_REG)) begin
			addr[FLASH_ADDR_W-1:8] <= wdat[FLASH_ADDR_W-9:0];
		end else if (ofs_step && addr[PAGE_OFS_W-1:0] != PAGE_LAST) begin
			addr[PAGE_OFS_W-1:0] <= addr[PAGE_OFS_W-1:0] + 5'h01; // RULE23 RULE25
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_lo <= 8'h00;
			data_hi <= 8'h00;
		end else if (rd_done) begin
			data_lo <= flash_rd[7:0]; // RULE18
			data_hi <= flash_rd[15:8];
		end else begin
			if (wr_to(IDX_D0L)) begin
				data_lo <= wdat;
			end
			if (wr_to(IDX_D0H)) begin
				data_hi <= wdat;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page write buffer and erase tags

	// The low byte is taken from the data register, so it must be written first
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < WORDS; i++) begin
				wbuf[i] <= '0;
			end
			tag <= '0;
		end else if (wr_to(IDX_FC1) && wdat[FC1_CLR_BIT]) begin
			for (int i = 0; i < WORDS; i++) begin
				wbuf[i] <= '0; // RULE3
			end
			tag <= '0;
		end else if (ew_done && state == ST_ERASE) begin
			tag <= '0;
		end else if (ofs_step && op_sel == MODE_WRITE) begin
			wbuf[addr[PAGE_OFS_W-1:0]] <= {wdat, data_lo}; // RULE4 RULE24
		end else if (ofs_step) begin
			tag[addr[PAGE_OFS_W-1:0]] <= 1'b1; // RULE23
		end
	end

	always_comb begin
		for (int i = 0; i < WORDS; i++) begin
			page_flat[i*WORD_W +: WORD_W] = wbuf[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operation sequencer

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state      <= ST_IDLE;
			cnt        <= 24'h00_0000;
			ew_last    <= 24'h00_0000;
			div        <= 2'h0;
			trig       <= 1'b0;
			rd_trig    <= 1'b0;
			cpu_halt_o <= 1'b0;
			op_page    <= '0;
		end else begin
			div <= (div == 2'(CLKS_PER_INSTR - 1)) ? 2'h0 : div + 2'h1;
			unique case (state)
				ST_IDLE: begin
					cnt <= 24'h00_0000;
					if (start_ew) begin
						state      <= (new_mode == MODE_ERASE) ? ST_ERASE : ST_WRITE;
						ew_last    <= tsel ? 24'(EW_LONG_CYC - 1) : 24'(EW_SHORT_CYC - 1); // RULE8
						op_page    <= addr[FLASH_ADDR_W-1:PAGE_OFS_W]; // RULE24
						trig       <= 1'b1;
						cpu_halt_o <= 1'b1; // RULE7
					end else if (start_rd) begin
						state      <= ST_READ;
						div        <= 2'h0;
						rd_trig    <= 1'b1;
						cpu_halt_o <= 1'b1; // RULE20
					end
				end
				ST_ERASE, ST_WRITE: begin
					cnt <= cnt + 24'h00_0001;
					if (ew_done) begin
						state      <= ST_IDLE;
						trig       <= 1'b0; // RULE1 RULE5
						cpu_halt_o <= 1'b0;
					end
				end
				ST_READ: begin
					if (div == 2'(CLKS_PER_INSTR - 1)) begin
						cnt <= cnt + 24'h00_0001;
					end
					if (rd_done) begin
						state      <= ST_IDLE;
						rd_trig    <= 1'b0; // RULE21
						cpu_halt_o <= 1'b0;
					end
				end
			endcase
		end
	end

	// An erase with no tagged word leaves the page alone
	fic_flash_array u_array (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_i),
		.erase_i     (ew_done && state == ST_ERASE && |tag), // RULE10
		.prog_i      (ew_done && state == ST_WRITE), // RULE2 RULE11 RULE12
		.page_i      (op_page),
		.page_data_i (page_flat),
		.rd_addr_i   (addr),
		.rd_data_o   (flash_rd)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_ew_needs_en;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(trig) |-> $past(en_flag);
	endproperty
	a_ew_needs_en: assert property (p_ew_needs_en) else $error("erase/write began while locked"); // RULE9

	property p_halt_busy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		cpu_halt_o == (trig || rd_trig);
	endproperty
	a_halt_busy: assert property (p_halt_busy) else $error("halt does not match busy"); // RULE7

	property p_read_len;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$rose(rd_trig) |-> rd_trig[*8] ##1 rd_trig[*4] ##1 !rd_trig;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read trigger length wrong"); // RULE21

	property p_read_start;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr_fc0 && state == ST_IDLE && wdat[0] && wdat[1] && wdat[6:4] == 3'h3) |=> rd_trig && cpu_halt_o;
	endproperty
	a_read_start: assert property (p_read_start) else $error("read did not start"); // RULE19

	property p_read_data;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		$fell(rd_trig) |-> {data_hi, data_lo} == $past(flash_rd);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data not loaded"); // RULE18

	property p_ofs_hold;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ofs_step && addr[4:0] == 5'h1F) |=> addr[4:0] == 5'h1F;
	endproperty
	a_ofs_hold: assert property (p_ofs_hold) else $error("buffer address passed page end"); // RULE25

	property p_tag;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(ofs_step && op_sel == 3'h1 && !wr_fc1) |=> tag[$past(addr[4:0])];
	endproperty
	a_tag: assert property (p_tag) else $error("erase tag not set"); // RULE23

	property p_clear;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr_fc1 && wdat[0]) |=> (page_flat == '0) && (tag == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("buffer not cleared"); // RULE3

	property p_unlock_end;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(arm && ucnt == 24'(UNLOCK_CYC - 1)) |=> !arm;
	endproperty
	a_unlock_end: assert property (p_unlock_end) else $error("unlock window did not close"); // RULE22

	property p_ew_time;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		trig |-> cnt <= ew_last;
	endproperty
	a_ew_time: assert property (p_ew_time) else $error("erase/write overran its time"); // RULE8

	c_erase: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) ew_done && state == ST_ERASE);
	c_write: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) ew_done && state == ST_WRITE);
	c_read: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $fell(rd_trig));
	c_unlock: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(en_flag));
endmodule

// >>> core/fic_pkg.sv
// Operation
// RULE1: Mode 001 plus trigger erases the addressed page; trigger stays high until done.
// RULE2: Mode 000 plus trigger moves the write buffer into the flash array.
// RULE3: Writing one to the buffer-clear bit empties the page write buffer.
// RULE4: Software writes each word low byte first, then high byte.
// RULE5: Write trigger clears itself on completion; software waits for that.
// RULE6: Software reloads the address pair before each non-adjacent word.
// RULE7: Processor is held while an erase or write runs.
// RULE8: Erase and write duration is chosen by a time-select bit in the third control register.
// RULE9: Erase and write only run while the erase/write-enabled flag is set.
// RULE10: Erase always clears a whole page. The code leaves the page alone when no word is tagged.
// RULE11: Write commits the whole buffer as one page, never crossing the boundary.
// RULE12: A repeated write to the same page without erase is accepted.
// RULE13: Software reads back and rewrites until each word matches.
// RULE14: Software blank-checks after erase and repeats on failure.
// RULE15: Clearing the enabled flag ends the erase/write-enabled state.
// RULE16: Software runs the system clock at full speed while programming.
// RULE17: Read needs mode 011 and the read-enable bit set.
// RULE18: Read trigger starts a read; data registers hold the word when it falls.
// RULE19: Reads work without unlocking.
// RULE20: Processor is held while a read runs.
// RULE21: Read trigger falls three instruction cycles after it was set.
// RULE22: Mode 110 plus arm starts a timer; correct six-byte key sets the enabled flag.
// RULE23: Erase-mode high-data writes tag the address and step it, holding at 11111b.
// RULE24: Write buffer holds 32 words, mapped to the page of address bits 12..5.
// RULE25: Write-mode high-data writes step the buffer address, holding at page end.
// RULE26: All controller registers are byte wide on the register bus.
package fic_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [7:0] IDX_FC0  = 8'h51;
	localparam logic [7:0] IDX_FC1  = 8'h52;
	localparam logic [7:0] IDX_FC2  = 8'h53;
	localparam logic [7:0] IDX_FLASH_ADDRESS_LOW_REG = 8'h54;
	localparam logic [7:0] IDX_FLASH_ADDRESS_HIGH_REG = 8'h55;
	localparam logic [7:0] IDX_D0L  = 8'h56;
	localparam logic [7:0] IDX_D0H  = 8'h57;
	localparam logic [7:0] IDX_K1L  = 8'h58;
	localparam logic [7:0] IDX_K3H  = 8'h5D;
	// Control register fields
	localparam int FC0_EN_BIT    = 7;
	localparam int FC0_MODE_LSB  = 4;
	localparam int FC0_ARM_BIT   = 3;
	localparam int FC0_TRIG_BIT  = 2;
	localparam int FC0_RDEN_BIT  = 1;
	localparam int FC0_RTRIG_BIT = 0;
	localparam int FC1_CLR_BIT   = 0;
	localparam int FC2_TSEL_BIT  = 0;
	// Operation select codes
	localparam logic [2:0] MODE_WRITE  = 3'h0;
	localparam logic [2:0] MODE_ERASE  = 3'h1;
	localparam logic [2:0] MODE_READ   = 3'h3;
	localparam logic [2:0] MODE_UNLOCK = 3'h6;
	localparam logic [2:0] MODE_RST    = 3'h0;
	// Key order: key low regs 1..3 then key high regs 1..3
	localparam logic [47:0] KEY_PATTERN = 48'h000DC3040940;
	// Geometry
	localparam int FLASH_ADDR_W = 13;
	localparam int WORD_W       = 16;
	localparam int PAGE_OFS_W   = 5;
	localparam logic [4:0] PAGE_LAST = 5'h1F;
	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int EW_SHORT_US       = 2000;
	localparam int EW_LONG_US        = 4000;
	localparam int UNLOCK_WINDOW_US  = 1000;
	localparam int INSTR_CYCLE_NS    = 40;
	localparam int READ_INSTR_CYCLES = 3;
	localparam int EW_SHORT_CYCLES   = EW_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int EW_LONG_CYCLES    = EW_LONG_US * 1000 / CLK_PERIOD_NS;
	localparam int UNLOCK_CYCLES     = UNLOCK_WINDOW_US * 1000 / CLK_PERIOD_NS;
	localparam int CLKS_PER_INSTR    = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE, ST_READ} fic_state_t;
endpackage

// >>> core/fic_flash_array.sv
module fic_flash_array import fic_pkg::*; #(
	parameter int ADDR_W = FLASH_ADDR_W,
	parameter int DATA_W = WORD_W,
	parameter int OFS_W  = PAGE_OFS_W
) (
	// Clock and reset
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_n_i,
	// Page operations
	input  wire logic                         erase_i,
	input  wire logic                         prog_i,
	input  wire logic [ADDR_W-OFS_W-1:0]      page_i,
	input  wire logic [(DATA_W<<OFS_W)-1:0]   page_data_i,
	// Word read
	input  wire logic [ADDR_W-1:0]            rd_addr_i,
	output logic      [DATA_W-1:0]            rd_data_o
);
	localparam int WORDS = 1 << OFS_W;
	logic [DATA_W-1:0] mem [1 << ADDR_W];

	// Programming only sets bits, so an unloaded buffer word leaves flash untouched
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < WORDS; i++) begin
			if (erase_i) begin
				mem[{page_i, OFS_W'(i)}] <= '0; // RULE10
			end else if (prog_i) begin
				mem[{page_i, OFS_W'(i)}] <= mem[{page_i, OFS_W'(i)}] | page_data_i[i*DATA_W +: DATA_W]; // RULE11 RULE12
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= '0;
		end else begin
			rd_data_o <= mem[rd_addr_i];
		end
	end
endmodule

// >>> testbench/tb_top.sv
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module tb_top import fic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P_SHORT = 20;
	localparam int P_LONG  = 40;
	localparam int P_UNL   = 50;

	logic        core_clk = 1'h0;
	logic        rst_n    = 1'h0;
	logic        cyc      = 1'h0;
	logic        stb      = 1'h0;
	logic        we       = 1'h0;
	logic [31:0] adr      = 32'h0;
	logic [3:0]  sel      = 4'h0;
	logic [31:0] dat      = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        cpu_halt_o;
	int          fails      = 0;
	int          num_checks = 0;
	int          run        = 0;
	int          last_run   = 0;
	int          runs       = 0;
	logic [31:0] seed       = 32'hDC63;
	logic        en_m       = 1'h0;
	logic [15:0] fm [int];
	logic [15:0] wbuf [32];

	fic_iap_ctrl #(.EW_SHORT_CYC(P_SHORT), .EW_LONG_CYC(P_LONG), .UNLOCK_CYC(P_UNL)) DUT (
		.core_clk_i (core_clk),
		.rst_n_i    (rst_n),
		.wb_cyc_i   (cyc),
		.wb_stb_i   (stb),
		.wb_we_i    (we),
		.wb_adr_i   (adr),
		.wb_sel_i   (sel),
		.wb_dat_i   (dat),
		.wb_dat_o   (wb_dat_o),
		.wb_ack_o   (wb_ack_o),
		.cpu_halt_o (cpu_halt_o)
	);

	always #5 core_clk = ~core_clk;

	// Length of the last processor hold, and how many holds have ended
	always @(posedge core_clk) begin
		if (cpu_halt_o === 1'h1) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_run <= run;
			runs <= runs + 1;
			run <= 0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
		int n;
		@(posedge core_clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {22'h0, idx, 2'h0};
		sel <= 4'hF;
		dat <= {24'h0, wd};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 64);
		if (n >= 64) begin
			fails++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		rd = wb_dat_o[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'h1, idx, d, x);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		bus(1'h0, idx, 8'h00, d);
	endtask

	task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		rd(idx, v);
		`CHK(v, exp)
	endtask

	// Polls the trigger bits; the bus stays served during a hold
	task automatic wait_done(input int r0);
		logic [7:0] v;
		int n;
		n = 0;
		do begin
			rd(IDX_FC0, v);
			n++;
		end while ((v[FC0_TRIG_BIT] | v[FC0_RTRIG_BIT]) !== 1'h0 && n < 200);
		`CHK(v[FC0_TRIG_BIT] | v[FC0_RTRIG_BIT], 1'h0)
		repeat (2) @(posedge core_clk);
		`CHK(runs, r0 + 1)
	endtask

	task automatic set_addr(input logic [12:0] a);
		wr(IDX_FLASH_ADDRESS_LOW_REG, a[7:0]);
		wr(IDX_FLASH_ADDRESS_HIGH_REG, {3'h0, a[12:8]});
	endtask

	task automatic rd_flash(input logic [12:0] a);
		logic [7:0] lo;
		logic [7:0] hi;
		set_addr(a);
		wr(IDX_FC0, {en_m, MODE_READ, 4'h3});
		wait_done(runs);
		`CHK(last_run, 12)
		rd(IDX_D0L, lo);
		rd(IDX_D0H, hi);
		`CHK({hi, lo}, fm[int'(a)])
	endtask

	task automatic unlock(input logic good);
		logic [7:0] b;
		wr(IDX_FC0, {en_m, MODE_UNLOCK, 4'h8});
		for (int i = 0; i < 6; i++) begin
			b = (i % 2 == 0) ? KEY_PATTERN[47 - 8 * (i / 2) -: 8] : KEY_PATTERN[23 - 8 * (i / 2) -: 8];
			if (!good && i == 5) begin
				b = b ^ 8'h01;
			end
			wr(IDX_K1L + 8'(i), b);
		end
	endtask

	task automatic erase(input logic [12:0] a, input int ntags, input logic long_t);
		int r0;
		wr(IDX_FC2, {7'h0, long_t});
		wr(IDX_FC0, {en_m, MODE_ERASE, 4'h0});
		wr(IDX_FC1, 8'h01);
		set_addr(a);
		repeat (ntags) wr(IDX_D0H, 8'h00);
		r0 = runs;
		wr(IDX_FC0, {en_m, MODE_ERASE, 4'h4});
		wait_done(r0);
		`CHK(last_run >= (long_t ? P_LONG : P_SHORT) && last_run <= (long_t ? P_LONG : P_SHORT) + 1, 1'h1)
		for (int i = 0; i < 32; i++) begin
			fm[int'({a[12:5], 5'(i)})] = 16'h0000;
		end
	endtask

	// Words land at the running offset, which holds at the page end
	task automatic write_words(input logic [12:0] a, input int n);
		int ofs;
		logic [15:0] d;
		wr(IDX_FC0, {en_m, MODE_WRITE, 4'h0});
		wr(IDX_FC1, 8'h01);
		foreach (wbuf[i]) wbuf[i] = 16'h0000;
		set_addr(a);
		ofs = a[4:0];
		for (int i = 0; i < n; i++) begin
			d = 16'(xs());
			wr(IDX_D0L, d[7:0]);
			wr(IDX_D0H, d[15:8]);
			wbuf[ofs] = d;
			ofs = (ofs < 31) ? ofs + 1 : 31;
		end
		wr(IDX_FC0, {en_m, MODE_WRITE, 4'h4});
		wait_done(runs);
		for (int i = 0; i < 32; i++) begin
			fm[int'({a[12:5], 5'(i)})] |= wbuf[i];
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report();
	end

	initial begin
		logic [7:0] page;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		page = 8'(xs());
		chk_rd(IDX_FC0, 8'h00);
		chk_rd(8'h50, 8'h00);
		wr(IDX_FC0, {1'h0, MODE_READ, 4'h1});
		chk_rd(IDX_FC0, 8'h30);
		$display("test reset and unmapped done");
		wr(IDX_FC0, {1'h0, MODE_ERASE, 4'h4});
		chk_rd(IDX_FC0, 8'h10);
		`CHK(cpu_halt_o, 1'h0)
		$display("test locked trigger done");
		unlock(1'h0);
		chk_rd(IDX_FC0, 8'h68);
		unlock(1'h1);
		en_m = 1'h1;
		chk_rd(IDX_FC0, 8'hE8);
		repeat (P_UNL + 5) @(posedge core_clk);
		chk_rd(IDX_FC0, 8'hE0);
		$display("test unlock done");
		erase({page, 5'h02}, 3, 1'h0);
		rd_flash({page, 5'h02});
		rd_flash({page, 5'h14});
		$display("test erase done");
		write_words({page, 5'h1E}, 3);
		rd_flash({page, 5'h1E});
		rd_flash({page, 5'h1F});
		rd_flash({page, 5'h00});
		$display("test page write done");
		write_words({page, 5'h1E}, 1);
		rd_flash({page, 5'h1E});
		rd_flash({page, 5'h1F});
		$display("test repeat write done");
		erase({page, 5'h00}, 1, 1'h1);
		rd_flash({page, 5'h1F});
		$display("test long erase done");
		wr(IDX_FC0, {1'h0, MODE_WRITE, 4'h0});
		en_m = 1'h0;
		chk_rd(IDX_FC0, 8'h00);
		wr(IDX_FC0, {1'h0, MODE_WRITE, 4'h4});
		chk_rd(IDX_FC0, 8'h00);
		rd_flash({page, 5'h1E});
		$display("test disable and locked read done");
		final_report();
	end
endmodule
